// *** hdl/eeprom_host_pkg.sv ***
// Constants shared by the two-wire memory host controller.
// Assumes a 125 MHz system clock and a bus target of the 256-byte write path kind.
package eeprom_host_pkg;

  // System clock
  localparam int CLK_PERIOD_NS = 8;

  // Bus timing: one bit is four quarters, 10 us per bit (100 kHz)
  localparam int QUARTER_NS     = 2500;
  localparam int QUARTER_CYCLES = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Self-timed nonvolatile write, longest time
  localparam int NONVOLATILE_WRITE_TIME_MS = 5;
  localparam int NONVOLATILE_WRITE_CYCLES  =
    (NONVOLATILE_WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;

  // Device address word fields
  localparam logic [3:0] CODE_MEMORY  = 4'ha;
  localparam logic [3:0] CODE_PROTECT = 4'h6;
  localparam logic       RW_WRITE     = 1'b0;
  localparam logic       RW_READ      = 1'b1;

  // Word and page layout, recovery clock count
  localparam int BYTE_BITS      = 8;
  localparam int PAGE_BYTES     = 16;
  localparam int RECOVER_CLOCKS = 9;

  // Command codes on the user port
  localparam logic [1:0] CMD_WRITE   = 2'h0;
  localparam logic [1:0] CMD_PROTECT = 2'h1;
  localparam logic [1:0] CMD_POLL    = 2'h2;
  localparam logic [1:0] CMD_RECOVER = 2'h3;

endpackage

// *** hdl/pin_sync.sv ***
// Three-stage synchroniser for one bus pin.
// Assumes the pin idles high, as a pulled-up open-drain line does.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // Pin and clean level
  input  wire logic i_pin,
  output logic      o_level
);

  logic s1_ff, s2_ff, s3_ff, level_ff;
  logic nxt_level;

  // Level moves only once the last two stages agree
  always_comb begin
    nxt_level = level_ff;
    if (s2_ff == s3_ff) begin
      nxt_level = s3_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_ff    <= 1'b1;
      s2_ff    <= 1'b1;
      s3_ff    <= 1'b1;
      level_ff <= 1'b1;
    end else begin
      s1_ff    <= i_pin;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign o_level = level_ff;

endmodule // pin_sync
`default_nettype wire

// *** hdl/tick_divider.sv ***
// Divider giving a one-cycle enable pulse every DIV clock cycles.
// Assumes DIV is at least 2.
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 313
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // Enable pulse
  output logic      o_tick
);

  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          tick_ff, nxt_tick;

  always_comb begin
    nxt_cnt  = cnt_ff + CW'(1);
    nxt_tick = 1'b0;
    if (cnt_ff == CW'(DIV - 1)) begin
      nxt_cnt  = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;

endmodule // tick_divider
`default_nettype wire

// *** hdl/eeprom_host.sv ***
// Two-wire bus host that writes a 256-byte serial memory: byte and page
// writes, protection register programming, acknowledge polling, bus recovery.
// Assumes open-drain pins with external pull-ups; the bench resolves the wires.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Start is data falling while clock high; every command but recovery opens with one.
// - Stop is data rising while clock high; it ends every command.
// - Data line changes only while clock low, except start and stop.
// - Recovery: up to nine clocks watching data high, then a start.
// - Address word opens with 1010 for memory, 0110 for protection register.
// - Last address bit: high reads, low writes.
// - Byte write: address word, word address, one data byte, stop.
// - Protected writes are still acknowledged; host still waits full write time.
// - Page write sends up to fifteen further data bytes before stop.
// - Host may poll with start and address word; acknowledge means write done.
module eeprom_host #(
  parameter int QUARTER_CYCLES = eeprom_host_pkg::QUARTER_CYCLES,
  parameter int WRITE_CYCLES   = eeprom_host_pkg::NONVOLATILE_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // Command port
  input  wire logic       i_start,
  input  wire logic [1:0] i_cmd,
  input  wire logic [2:0] i_strap,
  input  wire logic [7:0] i_word_addr,
  input  wire logic [3:0] i_len,
  input  wire logic [7:0] i_data,
  output logic            o_data_take,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_nack,
  // Serial clock pin, open drain
  input  wire logic       i_scl,
  output logic            o_scl_o,
  output logic            o_scl_oe,
  // Serial data pin, open drain
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe
);

  localparam int WW = $clog2(WRITE_CYCLES + 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BIT, ST_STOP, ST_FREE, ST_WRWAIT, ST_RECOVER
  } state_type;

  // Device address word from control code, straps and direction
  function automatic logic [7:0] addr_word(input logic [3:0] code,
                                           input logic [2:0] strap,
                                           input logic       rw);
    addr_word = {code, strap, rw};
  endfunction

  // Index of the last byte a command sends
  function automatic logic [4:0] last_byte(input logic [1:0] cmd,
                                           input logic [3:0] len);
    case (cmd)
      eeprom_host_pkg::CMD_POLL:    last_byte = 5'h00;
      eeprom_host_pkg::CMD_PROTECT: last_byte = 5'h02;
      default:                      last_byte = 5'h02 + {1'b0, len};
    endcase
  endfunction

  logic tick, scl_s, sda_s;

  tick_divider #(
    .DIV (QUARTER_CYCLES)
  ) u_quarter (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .o_tick (tick)
  );

  pin_sync u_scl_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_pin   (i_scl),
    .o_level (scl_s)
  );

  pin_sync u_sda_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_pin   (i_sda),
    .o_level (sda_s)
  );

  state_type      state_ff, nxt_state;
  logic [1:0]     q_ff, nxt_q;
  logic [3:0]     cnt_ff, nxt_cnt;
  logic [4:0]     byte_ff, nxt_byte;
  logic [7:0]     shift_ff, nxt_shift;
  logic [1:0]     cmd_ff, nxt_cmd;
  logic [7:0]     waddr_ff, nxt_waddr;
  logic [3:0]     len_ff, nxt_len;
  logic           wrote_ff, nxt_wrote;
  logic           scl_oe_ff, nxt_scl_oe;
  logic           sda_oe_ff, nxt_sda_oe;
  logic           take_ff, nxt_take;
  logic           busy_ff, nxt_busy;
  logic           done_ff, nxt_done;
  logic           nack_ff, nxt_nack;
  logic [WW-1:0]  wait_ff, nxt_wait;
  logic           low_ff;

  always_comb begin
    nxt_state  = state_ff;
    nxt_q      = q_ff;
    nxt_cnt    = cnt_ff;
    nxt_byte   = byte_ff;
    nxt_shift  = shift_ff;
    nxt_cmd    = cmd_ff;
    nxt_waddr  = waddr_ff;
    nxt_len    = len_ff;
    nxt_wrote  = wrote_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_take   = 1'b0;
    nxt_busy   = busy_ff;
    nxt_done   = 1'b0;
    nxt_nack   = nack_ff;
    nxt_wait   = wait_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_scl_oe = 1'b0;
        nxt_sda_oe = 1'b0;
        if (i_start) begin
          nxt_cmd   = i_cmd;
          nxt_waddr = i_word_addr;
          nxt_len   = i_len;
          nxt_wrote = 1'b0;
          nxt_nack  = 1'b0;
          nxt_busy  = 1'b1;
          nxt_byte  = '0;
          nxt_cnt   = '0;
          nxt_q     = '0;
          nxt_shift = addr_word((i_cmd == eeprom_host_pkg::CMD_PROTECT) ?
                                eeprom_host_pkg::CODE_PROTECT :
                                eeprom_host_pkg::CODE_MEMORY,
                                i_strap, eeprom_host_pkg::RW_WRITE);
          nxt_state = (i_cmd == eeprom_host_pkg::CMD_RECOVER) ? ST_RECOVER : ST_START;
        end
      end
      ST_START: begin
        if (tick) begin
          nxt_q = q_ff + 2'h1;
          case (q_ff)
            2'h0: begin
              nxt_sda_oe = 1'b0;
              nxt_scl_oe = 1'b0;
            end
            2'h2: nxt_sda_oe = 1'b1;
            2'h3: begin
              // Clock held low by a stretching target delays the bit or stop that follows the start
              if (!scl_s) begin
                nxt_q = q_ff;
              end else if (cmd_ff == eeprom_host_pkg::CMD_RECOVER) begin
                nxt_state = ST_STOP;
              end else begin
                nxt_state = ST_BIT;
              end
            end
            default: ;
          endcase
        end
      end
      ST_BIT: begin
        if (tick) begin
          nxt_q = q_ff + 2'h1;
          case (q_ff)
            2'h0: begin
              nxt_scl_oe = 1'b1;
              // Ninth clock left free for the target's acknowledge
              nxt_sda_oe = (cnt_ff == 4'h8) ? 1'b0 : ~shift_ff[7];
            end
            2'h2: nxt_scl_oe = 1'b0;
            2'h3: begin
              if (!scl_s) begin
                nxt_q = q_ff;
              end else if (cnt_ff != 4'h8) begin
                nxt_cnt   = cnt_ff + 4'h1;
                nxt_shift = {shift_ff[6:0], 1'b0};
              end else begin
                nxt_cnt = '0;
                if (sda_s) begin
                  nxt_nack  = 1'b1;
                  nxt_state = ST_STOP;
                end else begin
                  if (byte_ff >= 5'h02) begin
                    nxt_wrote = 1'b1;
                  end
                  if (byte_ff == last_byte(cmd_ff, len_ff)) begin
                    nxt_state = ST_STOP;
                  end else begin
                    nxt_byte = byte_ff + 5'h01;
                    if (byte_ff == 5'h00) begin
                      nxt_shift = waddr_ff;
                    end else begin
                      nxt_shift = i_data;
                      nxt_take  = 1'b1;
                    end
                  end
                end
              end
            end
            default: ;
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          nxt_q = q_ff + 2'h1;
          case (q_ff)
            2'h0: begin
              nxt_scl_oe = 1'b1;
              nxt_sda_oe = 1'b1;
            end
            2'h2: nxt_scl_oe = 1'b0;
            2'h3: begin
              if (!scl_s) begin
                nxt_q = q_ff;
              end else begin
                nxt_state = ST_FREE;
              end
            end
            default: ;
          endcase
        end
      end
      ST_FREE: begin
        if (tick) begin
          nxt_q = q_ff + 2'h1;
          if (q_ff == 2'h0) begin
            nxt_sda_oe = 1'b0;
          end
          // Three quarters of idle bus before the next start
          if (q_ff == 2'h3) begin
            nxt_wait = '0;
            if (wrote_ff) begin
              nxt_state = ST_WRWAIT;
            end else begin
              nxt_state = ST_IDLE;
              nxt_busy  = 1'b0;
              nxt_done  = 1'b1;
            end
          end
        end
      end
      ST_WRWAIT: begin
        // Full time even for a protected write, which looks identical
        nxt_wait = wait_ff + WW'(1);
        if (wait_ff == WW'(WRITE_CYCLES - 1)) begin
          nxt_state = ST_IDLE;
          nxt_busy  = 1'b0;
          nxt_done  = 1'b1;
        end
      end
      ST_RECOVER: begin
        if (tick) begin
          nxt_q = q_ff + 2'h1;
          case (q_ff)
            2'h0: begin
              nxt_scl_oe = 1'b1;
              nxt_sda_oe = 1'b0;
            end
            2'h2: nxt_scl_oe = 1'b0;
            2'h3: begin
              if (!scl_s) begin
                nxt_q = q_ff;
              end else if (sda_s) begin
                nxt_state = ST_START;
              end else if (cnt_ff == 4'(eeprom_host_pkg::RECOVER_CLOCKS - 1)) begin
                // Data still held low: report it and try a stop anyway
                nxt_nack  = 1'b1;
                nxt_state = ST_STOP;
              end else begin
                nxt_cnt = cnt_ff + 4'h1;
              end
            end
            default: ;
          endcase
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_ff  <= ST_IDLE;
      q_ff      <= '0;
      cnt_ff    <= '0;
      byte_ff   <= '0;
      shift_ff  <= '0;
      cmd_ff    <= eeprom_host_pkg::CMD_WRITE;
      waddr_ff  <= '0;
      len_ff    <= '0;
      wrote_ff  <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      take_ff   <= 1'b0;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      nack_ff   <= 1'b0;
      wait_ff   <= '0;
      low_ff    <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      q_ff      <= nxt_q;
      cnt_ff    <= nxt_cnt;
      byte_ff   <= nxt_byte;
      shift_ff  <= nxt_shift;
      cmd_ff    <= nxt_cmd;
      waddr_ff  <= nxt_waddr;
      len_ff    <= nxt_len;
      wrote_ff  <= nxt_wrote;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      take_ff   <= nxt_take;
      busy_ff   <= nxt_busy;
      done_ff   <= nxt_done;
      nack_ff   <= nxt_nack;
      wait_ff   <= nxt_wait;
      low_ff    <= 1'b0;
    end
  end

  // Open drain: only ever pull low
  assign o_scl_o     = low_ff;
  assign o_sda_o     = low_ff;
  assign o_scl_oe    = scl_oe_ff;
  assign o_sda_oe    = sda_oe_ff;
  assign o_data_take = take_ff;
  assign o_busy      = busy_ff;
  assign o_done      = done_ff;
  assign o_nack      = nack_ff;

endmodule // eeprom_host
`default_nettype wire

// *** tb/eeprom_host_monitor.sv ***
// Checker for the two-wire memory host: framing, handshake, write wait.
// Assumes it is bound into eeprom_host and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_monitor #(
  parameter int QUARTER_CYCLES = 5,
  parameter int WRITE_CYCLES   = 50
) (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_srst,
  // Command port
  input wire logic       i_start,
  input wire logic [1:0] i_cmd,
  input wire logic       o_busy,
  input wire logic       o_done,
  input wire logic       o_nack,
  // Bus
  input wire logic       i_scl,
  input wire logic       o_scl_oe,
  input wire logic       o_sda_oe
);
  logic [1:0] cmd_ff;
  int         idle_ff;

  // Idle bus time is what the write wait is judged by
  always_ff @(posedge i_clk) begin
    if (i_start && !o_busy) cmd_ff <= i_cmd;
    if (i_srst || o_scl_oe || o_sda_oe) idle_ff <= 0;
    else idle_ff <= idle_ff + 1;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_start_form: assert property ($rose(o_sda_oe) && !o_scl_oe |-> i_scl && !$past(o_scl_oe, 4))
    else $error("data pulled while clock low");
  a_stop_form: assert property ($fell(o_sda_oe) && !o_scl_oe |-> i_scl && !$past(o_scl_oe, 4))
    else $error("stop without clock high");
  a_data_steady: assert property ($fell(o_scl_oe) |=> $stable(o_sda_oe) [*4])
    else $error("data moved in clock high");
  a_clock_low: assert property ($rose(o_scl_oe) |=> o_scl_oe [*8])
    else $error("clock low phase too short");
  a_done_free: assert property (o_done |-> !o_busy && !o_scl_oe && !o_sda_oe)
    else $error("done with bus held");
  a_accept_busy: assert property (i_start && !o_busy |=> o_busy && !o_nack)
    else $error("command not taken");
  a_write_wait: assert property (o_done && !o_nack && cmd_ff <= eeprom_host_pkg::CMD_PROTECT
    |-> idle_ff >= WRITE_CYCLES)
    else $error("write wait cut short");
  a_poll_nowait: assert property (o_done && cmd_ff == eeprom_host_pkg::CMD_POLL
    |-> idle_ff < WRITE_CYCLES)
    else $error("poll waited");
  a_nack_nowait: assert property (o_done && o_nack && cmd_ff == eeprom_host_pkg::CMD_WRITE
    |-> idle_ff < WRITE_CYCLES)
    else $error("refused write waited");

  c_protect: cover property (o_done && !o_nack && cmd_ff == eeprom_host_pkg::CMD_PROTECT);
  c_refused: cover property (o_done && o_nack);
  c_recover: cover property (o_done && cmd_ff == eeprom_host_pkg::CMD_RECOVER);
endmodule // eeprom_host_monitor

bind eeprom_host eeprom_host_monitor #(
  .QUARTER_CYCLES(QUARTER_CYCLES),
  .WRITE_CYCLES(WRITE_CYCLES)
) u_monitor (
  .i_clk(i_clk), .i_srst(i_srst), .i_start(i_start), .i_cmd(i_cmd),
  .o_busy(o_busy), .o_done(o_done), .o_nack(o_nack), .i_scl(i_scl),
  .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe)
);
`default_nettype wire

// *** tb/eeprom_target_model.sv ***
// Behavioural 256-byte serial memory target with page wrap and protection.
// Assumes resolved wires with pull-ups; data lags clock edges slightly.
`timescale 1ns/1ps
`default_nettype none
module eeprom_target_model #(
  parameter logic [2:0] STRAP   = 3'h5,
  parameter int         BUSY_NS = 500
) (
  // Write-protect pin
  input  wire logic i_wp,
  // Bus wires
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_oe
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] addr;
  logic [3:0] code;
  int         nbit;
  int         nbyte;
  logic       live;
  logic       wrote;
  logic       busy;
  logic       prot;

  initial begin
    o_sda_oe = 1'b0;
    live = 1'b0;
    wrote = 1'b0;
    busy = 1'b0;
    prot = 1'b0;
    foreach (mem[i]) mem[i] = 8'hff;
  end

  // Starts are ignored while the write cycle runs, so polls go unanswered
  always @(negedge i_sda) begin
    if (i_scl && !busy) begin
      live = 1'b1;
      nbit = 0;
      nbyte = 0;
      wrote = 1'b0;
    end
  end

  always @(posedge i_sda) begin
    if (i_scl) begin
      live = 1'b0;
      if (wrote) begin
        if (code == 4'h6 && !i_wp) prot = 1'b1;
        wrote = 1'b0;
        busy = 1'b1;
        busy <= #(BUSY_NS) 1'b0;
      end
    end
  end

  always @(posedge i_scl) begin
    if (live && nbit == 8) begin
      nbit = 0;
      nbyte++;
    end else if (live) begin
      sh = {sh[6:0], i_sda};
      nbit++;
    end
  end

  always @(negedge i_scl) begin
    o_sda_oe = 1'b0;
    if (live && nbit == 8) begin
      if (nbyte == 0) begin
        code = sh[7:4];
        live = sh[3:1] == STRAP && (code == 4'ha || (code == 4'h6 && !prot));
      end else if (nbyte == 1) begin
        addr = sh;
      end else begin
        wrote = 1'b1;
        if (code == 4'ha && !i_wp && !(prot && !addr[7])) mem[addr] = sh;
        addr[3:0] = addr[3:0] + 4'h1;
      end
      o_sda_oe = live;
    end
  end
endmodule // eeprom_target_model
`default_nettype wire

// *** tb/tb_eeprom_host.sv ***
// Bench for the memory host, driving a behavioural target over resolved wires.
// Assumes the target model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module tb_eeprom_host;
  localparam int QC = 5;
  localparam int WC = 50;

  logic       i_clk       = 1'b0;
  logic       i_srst      = 1'b1;
  logic       i_start     = 1'b0;
  logic [1:0] i_cmd       = 2'h0;
  logic [2:0] i_strap     = 3'h0;
  logic [7:0] i_word_addr = 8'h00;
  logic [3:0] i_len       = 4'h0;
  logic [7:0] i_data      = 8'h00;
  logic       wp          = 1'b0;
  logic       stuck       = 1'b0;
  logic       o_data_take;
  logic       o_busy;
  logic       o_done;
  logic       o_nack;
  logic       o_scl_o;
  logic       o_scl_oe;
  logic       o_sda_o;
  logic       o_sda_oe;
  logic       dev_oe;
  wire        scl_w;
  wire        sda_w;
  int         failures    = 0;
  int         comparisons = 0;
  int         takes       = 0;
  logic [7:0] q [$];

  always #4 i_clk = ~i_clk;
  assign scl_w = !o_scl_oe;
  // Data lags the clock edge so a bit change never looks like start or stop
  assign #2 sda_w = !(o_sda_oe || dev_oe || stuck);

  eeprom_host #(.QUARTER_CYCLES(QC), .WRITE_CYCLES(WC)) dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_start(i_start), .i_cmd(i_cmd),
    .i_strap(i_strap), .i_word_addr(i_word_addr), .i_len(i_len), .i_data(i_data),
    .o_data_take(o_data_take), .o_busy(o_busy), .o_done(o_done), .o_nack(o_nack),
    .i_scl(scl_w), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
    .i_sda(sda_w), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe));

  eeprom_target_model #(.STRAP(3'h5), .BUSY_NS(500)) target (
    .i_wp(wp), .i_scl(scl_w), .i_sda(sda_w), .o_sda_oe(dev_oe));

  task automatic final_report();
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  // Feeds the next byte after each take and holds start until accepted
  task automatic run(input logic [1:0] cmd, input logic [2:0] strap, input logic [7:0] addr);
    int k;
    int n;
    k = 0;
    n = 0;
    takes = 0;
    i_cmd = cmd;
    i_strap = strap;
    i_word_addr = addr;
    i_len = 4'(q.size() - 1);
    i_data = q[0];
    i_start = 1'b1;
    do begin
      @(posedge i_clk);
      #1;
      n++;
      if (o_busy === 1'b1) i_start = 1'b0;
      if (o_data_take === 1'b1) begin
        takes++;
        if (k + 1 < q.size()) begin
          k++;
          i_data = q[k];
        end
      end
    end while (o_done !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      failures++;
      final_report();
    end
  endtask

  task automatic byte_write();
    q = '{8'h5a};
    run(eeprom_host_pkg::CMD_WRITE, 3'h5, 8'h93);
    check_flag(o_nack, 1'b0);
    check_byte(8'(takes), 8'h01);
    check_flag(o_scl_o | o_sda_o, 1'b0);
    check_byte(target.mem[8'h93], 8'h5a);
  endtask

  task automatic page_wrap();
    q = '{8'h11, 8'h22, 8'h33, 8'h44};
    run(eeprom_host_pkg::CMD_WRITE, 3'h5, 8'h2e);
    check_flag(o_nack, 1'b0);
    check_byte(8'(takes), 8'h04);
    check_byte(target.mem[8'h2f], 8'h22);
    check_byte(target.mem[8'h20], 8'h33);
    check_byte(target.mem[8'h21], 8'h44);
    check_byte(target.mem[8'h30], 8'hff);
  endtask

  task automatic wrong_strap();
    q = '{8'h77};
    for (int i = 0; i < 3; i++) begin
      run(eeprom_host_pkg::CMD_WRITE, 3'h5 ^ (3'h1 << i), 8'h40);
      check_flag(o_nack, 1'b1);
    end
    check_byte(target.mem[8'h40], 8'hff);
    run(eeprom_host_pkg::CMD_POLL, 3'h5, 8'h00);
    check_flag(o_nack, 1'b0);
  endtask

  task automatic wp_write();
    wp = 1'b1;
    q = '{8'h66};
    run(eeprom_host_pkg::CMD_WRITE, 3'h5, 8'hc0);
    check_flag(o_nack, 1'b0);
    check_byte(target.mem[8'hc0], 8'hff);
    wp = 1'b0;
  endtask

  task automatic recover();
    stuck = 1'b1;
    run(eeprom_host_pkg::CMD_RECOVER, 3'h5, 8'h00);
    check_flag(o_nack, 1'b1);
    stuck = 1'b0;
    run(eeprom_host_pkg::CMD_RECOVER, 3'h5, 8'h00);
    check_flag(o_nack, 1'b0);
  endtask

  task automatic protect();
    q = '{8'h00};
    run(eeprom_host_pkg::CMD_PROTECT, 3'h5, 8'h00);
    check_flag(o_nack, 1'b0);
    q = '{8'hab};
    run(eeprom_host_pkg::CMD_WRITE, 3'h5, 8'h10);
    check_flag(o_nack, 1'b0);
    check_byte(target.mem[8'h10], 8'hff);
    run(eeprom_host_pkg::CMD_WRITE, 3'h5, 8'h90);
    check_byte(target.mem[8'h90], 8'hab);
    run(eeprom_host_pkg::CMD_PROTECT, 3'h5, 8'h00);
    check_flag(o_nack, 1'b1);
  endtask

  initial begin
    repeat (16) @(posedge i_clk);
    #1 i_srst = 1'b0;
    byte_write();
    page_wrap();
    wrong_strap();
    wp_write();
    recover();
    protect();
    final_report();
  end
endmodule // tb_eeprom_host
`default_nettype wire
